/* dv/asfl_apb_host.sv */
// apb master standing in for the processor core
`timescale 1ns/1ps
`default_nettype none
module asfl_apb_host
(
   // clock and answer
   input  wire logic        pclk,
   input  wire logic        pready,
   input  wire logic [31:0] prdata,
   input  wire logic        pslverr,
   // request
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [31:0]      paddr,
   output logic [31:0]      pwdata
);
   initial {psel, penable, pwrite, paddr, pwdata} <= '0;
   task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d,
      output logic [31:0] q, output logic e);
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      {psel, penable} <= 2'b00;
   endtask
endmodule
`default_nettype wire

/* dv/test_adc_status_flag_logic.sv */
// testbench: status flags, clamping and apb access of the converter status logic
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin fails++; \
   $display("BAD %s exp %h got %h", n, e, s); end end
module test_adc_status_flag_logic;
   import asfl_pkg::*;
   localparam int OT = 20;
   logic pclk = 0, presetn = 0, cal_done = 0, gross_ovr_in = 0;
   logic [2:0] vld = 0;
   logic signed [17:0] raw = 0;
   logic psel, penable, pwrite, pready, pslverr, adc_irq;
   logic [31:0] paddr, pwdata, prdata, q;
   logic se;
   wire logic [7:0] mode_o, setup_o, gain_o;
   int fails = 0, checks_done = 0, cyc = 0;
   always #5 pclk = ~pclk;
   asfl_top #(.OVR_TICKS(OT)) i_asfl_top (.pclk(pclk), .presetn(presetn), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .cal_done(cal_done), .cur_valid(vld[0]),
      .cur_raw(raw), .volt_valid(vld[1]), .volt_raw(raw), .temp_valid(vld[2]),
      .temp_raw(raw), .gross_ovr_in(gross_ovr_in), .adc_mode_cfg(mode_o),
      .adc_setup_cfg(setup_o), .current_gain_ctrl(gain_o), .adc_irq(adc_irq));
   asfl_apb_host i_asfl_apb_host (.pclk(pclk), .pready(pready), .prdata(prdata),
      .pslverr(pslverr),
      .psel(psel), .penable(penable), .paddr(paddr), .pwrite(pwrite), .pwdata(pwdata));
   function automatic logic [15:0] clamp(input logic signed [17:0] r);
      return (r > 32767) ? ASFL_POS_FS : (r < -32768) ? ASFL_NEG_FS : r[15:0];
   endfunction
   task automatic close_out();
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      i_asfl_apb_host.xfer(a, 1'b1, d, q, se);
   endtask
   task automatic rd(input logic [31:0] a, input logic [31:0] e);
      i_asfl_apb_host.xfer(a, 1'b0, 32'h0, q, se);
      `CHK("read", e, q)
   endtask
   // only the bit under test is judged
   task automatic sta(input int b, input logic e);
      i_asfl_apb_host.xfer(ASFL_A_STATUS, 1'b0, 32'h0, q, se);
      `CHK("status bit", e, q[b])
   endtask
   task automatic conv(input int ch, input logic signed [17:0] r);
      vld <= 3'(1 << ch);
      raw <= r;
      @(posedge pclk);
      vld <= 3'b000;
      // threshold flag follows the stored result by one cycle
      @(posedge pclk);
   endtask
   always @(posedge pclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         fails++;
         close_out();
      end
   end
   initial
   begin
      logic signed [17:0] r;
      void'($urandom(83));
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      rd(ASFL_A_STATUS, 32'h0);
      wr(ASFL_A_STATUS, 32'hFFFF);
      `CHK("slverr", 1'b0, se)
      rd(ASFL_A_STATUS, 32'h0);
      rd(32'hFFFF05FC, 32'h0);
      `CHK("slverr", 1'b1, se)
      cal_done <= 1'b1;
      @(posedge pclk);
      cal_done <= 1'b0;
      sta(15, 1'b1);
      wr(ASFL_A_MODE, 32'h5A);
      sta(15, 1'b0);
      // in range, over, under, in range again on every channel
      for (int ch = 0; ch < 3; ch++)
         for (int k = 0; k < 4; k++)
         begin
            r = (k == 1) ? 18'sh08000 : (k == 2) ? 18'sh37FFF : 18'(signed'(16'($urandom)));
            conv(ch, r);
            rd(ASFL_A_CUR + 32'(4 * ch), 32'(clamp(r)));
            sta(ASFL_STA_CERR + ch, k inside {1, 2});
         end
      wr(ASFL_A_THRESH, 32'd100);
      wr(ASFL_A_SETUP, 32'h08);
      conv(0, 18'sd100);
      sta(4, 1'b0);
      conv(0, -18'sd101);
      sta(4, 1'b1);
      wr(ASFL_A_SETUP, 32'h00);
      sta(4, 1'b0);
      wr(ASFL_A_CLIMIT, 32'd1);
      wr(ASFL_A_CVALUE, 32'd2);
      wr(ASFL_A_SETUP, 32'h08);
      conv(0, 18'sd500);
      sta(4, 1'b0);
      conv(0, 18'sd500);
      sta(4, 1'b1);
      gross_ovr_in <= 1'b1;
      repeat (3 * OT) @(posedge pclk);
      sta(3, 1'b0);
      wr(ASFL_A_SETUP, 32'h04);
      repeat (2 * OT + 4) @(posedge pclk);
      sta(3, 1'b1);
      gross_ovr_in <= 1'b0;
      repeat (2 * OT + 4) @(posedge pclk);
      sta(3, 1'b1);
      wr(ASFL_A_MASK, 32'h08);
      @(negedge pclk);
      `CHK("irq", 1'b1, adc_irq)
      wr(ASFL_A_GAIN, 32'h01);
      sta(3, 1'b0);
      @(negedge pclk);
      `CHK("irq", 1'b0, adc_irq)
      `CHK("cfg", 24'h5A0401, {mode_o, setup_o, gain_o})
      close_out();
   end
endmodule
`default_nettype wire

/* src/asfl_chan.sv */
// module: per-channel range check, result clamp and error flag of the latest conversion
`timescale 1ns/1ps
`default_nettype none
module asfl_chan
   import asfl_pkg::*;
(
   // clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // conversion channel
   asfl_conv_if.chan port
);
   wire logic over_w;
   wire logic under_w;
   wire logic [ASFL_DATA_W-1:0] next_result;

   assign over_w      = port.raw > $signed({{(ASFL_RAW_W-ASFL_DATA_W+1){1'b0}}, ASFL_POS_FS[14:0]});
   assign under_w     = port.raw < $signed({{(ASFL_RAW_W-ASFL_DATA_W+1){1'b1}}, ASFL_NEG_FS[14:0]});
   // clamp to full scale on range error
   assign next_result = over_w  ? ASFL_POS_FS :
                        under_w ? ASFL_NEG_FS :
                        port.raw[ASFL_DATA_W-1:0];

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         port.result <= ASFL_WORD_RST;
         port.err    <= 1'b0;
         port.wr     <= 1'b0;
      end
      else
      begin
         port.wr <= port.valid;
         if (port.valid)
         begin
            port.result <= next_result;
            port.err    <= over_w | under_w;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   clamp_over_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      port.valid && over_w |=> port.result == ASFL_POS_FS && port.err && port.wr)
      else $error("overrange result not clamped to positive full scale");
   clamp_under_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      port.valid && under_w |=> port.result == ASFL_NEG_FS && port.err)
      else $error("underrange result not clamped to negative full scale");
   err_clear_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      port.valid && !over_w && !under_w |=> !port.err && port.result == $past(port.raw[15:0]))
      else $error("in-range result did not clear error flag");
   err_hold_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      !port.valid |=> $stable(port.err) && $stable(port.result))
      else $error("error flag or result changed without a conversion");
endmodule
`default_nettype wire

/* src/asfl_conv_if.sv */
// interface: one conversion channel between the status logic and its clamp stage
`timescale 1ns/1ps
`default_nettype none
interface asfl_conv_if
   import asfl_pkg::*;
();
   logic                         valid;
   logic signed [ASFL_RAW_W-1:0] raw;
   logic [ASFL_DATA_W-1:0]       result;
   logic                         err;
   logic                         wr;

   modport src  (output valid, output raw, input result, input err, input wr);
   modport chan (input valid, input raw, output result, output err, output wr);
endinterface
`default_nettype wire

/* src/asfl_pkg.sv */
// package: constants, register map and field layout of the converter status logic
// Function
// - sixteen-bit status word, read only, resets to all zeros
// - calibration-done bit 15 set by hardware when calibration completes
// - any write to adc_mode_cfg clears the calibration-done bit; here a completion in the same cycle wins and sets it
// - bit 14 set on temperature conversion over- or underrange
// - erroneous conversions stored clamped to negative or positive full scale
// - in-range temperature result written to temperature_result clears bit 14
// - bit 13 set on voltage conversion over- or underrange
// - in-range voltage result written to voltage_result clears bit 13
// - bit 12 set on current conversion over- or underrange
// - in-range current result written to current_result clears bit 12
// - threshold bit 4 meaningful only while current comparator enabled
// - threshold bit set when absolute current result exceeds current_threshold_value
// - with counting in use, set only when exceed count equals threshold_count_value
// - gross-overrange bit 3 evaluated only while overrange detection enabled
// - gross-overrange bit set when current input grossly overranged
// - gross-overrange bit re-evaluated every 125 microseconds
// - gross-overrange bit sticky until enable bit 2 cleared or gain written
// - lower eight status bits masked by adc_irq_mask, ORed into one interrupt
`default_nettype none
package asfl_pkg;
   // widths
   localparam int ASFL_DATA_W   = 16;
   localparam int ASFL_RAW_W    = 18;
   localparam int ASFL_BYTE_W   = 8;
   localparam int ASFL_CNT_W    = 16;
   localparam int ASFL_NUM_CH   = 3;
   localparam int ASFL_CH_CUR   = 0;
   localparam int ASFL_CH_VOLT  = 1;
   localparam int ASFL_CH_TEMP  = 2;
   // register byte addresses
   localparam logic [31:0] ASFL_A_STATUS  = 32'hFFFF0500;
   localparam logic [31:0] ASFL_A_MASK    = 32'hFFFF0504;
   localparam logic [31:0] ASFL_A_MODE    = 32'hFFFF0508;
   localparam logic [31:0] ASFL_A_CUR     = 32'hFFFF0510;
   localparam logic [31:0] ASFL_A_VOLT    = 32'hFFFF0514;
   localparam logic [31:0] ASFL_A_TEMP    = 32'hFFFF0518;
   localparam logic [31:0] ASFL_A_SETUP   = 32'hFFFF051C;
   localparam logic [31:0] ASFL_A_THRESH  = 32'hFFFF0520;
   localparam logic [31:0] ASFL_A_CLIMIT  = 32'hFFFF0524;
   localparam logic [31:0] ASFL_A_CVALUE  = 32'hFFFF0528;
   localparam logic [31:0] ASFL_A_GAIN    = 32'hFFFF052C;
   localparam logic [31:0] ASFL_A_COUNT   = 32'hFFFF0530;
   // status field positions
   localparam int ASFL_STA_CAL   = 15;
   localparam int ASFL_STA_TERR  = 14;
   localparam int ASFL_STA_VERR  = 13;
   localparam int ASFL_STA_CERR  = 12;
   localparam int ASFL_STA_THR   = 4;
   localparam int ASFL_STA_GOVR  = 3;
   localparam int ASFL_RSV_HI    = 11;
   localparam int ASFL_RSV_LO    = 5;
   // adc_setup_cfg field positions
   localparam int ASFL_CFG_OVR_EN = 2;
   localparam int ASFL_CFG_CMP_EN = 3;
   // reset values and clamp codes
   localparam logic [15:0] ASFL_STA_RST = 16'h0000;
   localparam logic [7:0]  ASFL_BYTE_RST = 8'h00;
   localparam logic [15:0] ASFL_WORD_RST = 16'h0000;
   localparam logic [15:0] ASFL_POS_FS   = 16'h7FFF;
   localparam logic [15:0] ASFL_NEG_FS   = 16'h8000;
   // gross-overrange evaluation interval
   localparam int ASFL_CLK_PERIOD_NS = 10;
   localparam int ASFL_OVR_PERIOD_NS = 125000;
   localparam int ASFL_OVR_TICKS     = ASFL_OVR_PERIOD_NS / ASFL_CLK_PERIOD_NS;
endpackage
`default_nettype wire

/* src/asfl_top.sv */
// module: converter status word, result registers and flag logic behind an APB slave
//
// Chosen here: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module asfl_top
   import asfl_pkg::*;
#(
   parameter int OVR_TICKS = ASFL_OVR_TICKS
)
(
   // clock and reset
   input  wire logic                         pclk,
   input  wire logic                         presetn,
   // apb slave
   input  wire logic [31:0]                  paddr,
   input  wire logic                         psel,
   input  wire logic                         penable,
   input  wire logic                         pwrite,
   input  wire logic [31:0]                  pwdata,
   output logic [31:0]                       prdata,
   output logic                              pready,
   output logic                              pslverr,
   // converter events from the filter stage
   input  wire logic                         cal_done,
   input  wire logic                         cur_valid,
   input  wire logic signed [ASFL_RAW_W-1:0] cur_raw,
   input  wire logic                         volt_valid,
   input  wire logic signed [ASFL_RAW_W-1:0] volt_raw,
   input  wire logic                         temp_valid,
   input  wire logic signed [ASFL_RAW_W-1:0] temp_raw,
   // gross overrange comparator, asynchronous
   input  wire logic                         gross_ovr_in,
   // configuration to the analog front end
   output logic [ASFL_BYTE_W-1:0]            adc_mode_cfg,
   output logic [ASFL_BYTE_W-1:0]            adc_setup_cfg,
   output logic [ASFL_BYTE_W-1:0]            current_gain_ctrl,
   // converter interrupt
   output logic                              adc_irq
);
   localparam int TICK_W = $clog2(OVR_TICKS + 1);
   localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(OVR_TICKS - 1);

   ////////////////////////////////////////////////////////////////////////////
   // state
   logic                     cal_flag;
   logic                     thr_flag;
   logic                     govr_flag;
   logic [ASFL_BYTE_W-1:0]   adc_irq_mask;
   logic [ASFL_DATA_W-1:0]   current_threshold_value;
   logic [ASFL_DATA_W-1:0]   threshold_count_limit;
   logic [ASFL_DATA_W-1:0]   threshold_count_value;
   logic [ASFL_CNT_W-1:0]    thr_cnt;
   logic [TICK_W-1:0]        tick_cnt;
   logic                     ovr_meta;
   logic                     ovr_sync;

   ////////////////////////////////////////////////////////////////////////////
   // conversion channels
   asfl_conv_if conv_if [ASFL_NUM_CH] ();

   wire logic [ASFL_NUM_CH-1:0]         ch_valid;
   wire logic signed [ASFL_RAW_W-1:0]   ch_raw [ASFL_NUM_CH];
   wire logic [ASFL_DATA_W-1:0]         ch_result [ASFL_NUM_CH];
   wire logic [ASFL_NUM_CH-1:0]         ch_err;
   wire logic [ASFL_NUM_CH-1:0]         ch_wr;

   assign ch_valid               = {temp_valid, volt_valid, cur_valid};
   assign ch_raw[ASFL_CH_CUR]    = cur_raw;
   assign ch_raw[ASFL_CH_VOLT]   = volt_raw;
   assign ch_raw[ASFL_CH_TEMP]   = temp_raw;

   genvar gi;
   generate
      for (gi = 0; gi < ASFL_NUM_CH; gi++)
      begin : g_ch
         assign conv_if[gi].valid = ch_valid[gi];
         assign conv_if[gi].raw   = ch_raw[gi];
         assign ch_result[gi]     = conv_if[gi].result;
         assign ch_err[gi]        = conv_if[gi].err;
         assign ch_wr[gi]         = conv_if[gi].wr;
         asfl_chan u_chan
         (
            .pclk    (pclk),
            .presetn (presetn),
            .port    (conv_if[gi].chan)
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // apb decode
   wire logic apb_acc;
   wire logic apb_wr;
   wire logic hit_status;
   wire logic hit_mask;
   wire logic hit_mode;
   wire logic hit_cur;
   wire logic hit_volt;
   wire logic hit_temp;
   wire logic hit_setup;
   wire logic hit_thresh;
   wire logic hit_climit;
   wire logic hit_cvalue;
   wire logic hit_gain;
   wire logic hit_count;
   wire logic hit_any;
   wire logic ro_hit;
   wire logic mode_wr;
   wire logic mask_wr;
   wire logic setup_wr;
   wire logic thresh_wr;
   wire logic climit_wr;
   wire logic cvalue_wr;
   wire logic gain_wr;

   assign apb_acc    = psel & penable;
   assign apb_wr     = apb_acc & pwrite;
   assign hit_status = paddr == ASFL_A_STATUS;
   assign hit_mask   = paddr == ASFL_A_MASK;
   assign hit_mode   = paddr == ASFL_A_MODE;
   assign hit_cur    = paddr == ASFL_A_CUR;
   assign hit_volt   = paddr == ASFL_A_VOLT;
   assign hit_temp   = paddr == ASFL_A_TEMP;
   assign hit_setup  = paddr == ASFL_A_SETUP;
   assign hit_thresh = paddr == ASFL_A_THRESH;
   assign hit_climit = paddr == ASFL_A_CLIMIT;
   assign hit_cvalue = paddr == ASFL_A_CVALUE;
   assign hit_gain   = paddr == ASFL_A_GAIN;
   assign hit_count  = paddr == ASFL_A_COUNT;
   assign ro_hit     = hit_status | hit_cur | hit_volt | hit_temp | hit_count;
   assign hit_any    = ro_hit | hit_mask | hit_mode | hit_setup | hit_thresh
                     | hit_climit | hit_cvalue | hit_gain;
   // writes to read-only words are dropped silently
   assign mode_wr    = apb_wr & hit_mode;
   assign mask_wr    = apb_wr & hit_mask;
   assign setup_wr   = apb_wr & hit_setup;
   assign thresh_wr  = apb_wr & hit_thresh;
   assign climit_wr  = apb_wr & hit_climit;
   assign cvalue_wr  = apb_wr & hit_cvalue;
   assign gain_wr    = apb_wr & hit_gain;

   assign pready     = 1'b1;
   assign pslverr    = apb_acc & ~hit_any;

   ////////////////////////////////////////////////////////////////////////////
   // status word and interrupt
   wire logic [ASFL_DATA_W-1:0] status_word;
   wire logic                   cmp_en;
   wire logic                   ovr_en;

   assign cmp_en = adc_setup_cfg[ASFL_CFG_CMP_EN];
   assign ovr_en = adc_setup_cfg[ASFL_CFG_OVR_EN];

   // reserved and ready positions read zero
   assign status_word = {cal_flag,
                         ch_err[ASFL_CH_TEMP],
                         ch_err[ASFL_CH_VOLT],
                         ch_err[ASFL_CH_CUR],
                         7'h00,
                         thr_flag & cmp_en,
                         govr_flag,
                         3'h0};

   assign adc_irq = |(status_word[ASFL_BYTE_W-1:0] & adc_irq_mask);

   ////////////////////////////////////////////////////////////////////////////
   // read mux
   wire logic [31:0] rd_mux;

   assign rd_mux = hit_status ? {16'h0000, status_word} :
                   hit_mask   ? {24'h000000, adc_irq_mask} :
                   hit_mode   ? {24'h000000, adc_mode_cfg} :
                   hit_cur    ? {16'h0000, ch_result[ASFL_CH_CUR]} :
                   hit_volt   ? {16'h0000, ch_result[ASFL_CH_VOLT]} :
                   hit_temp   ? {16'h0000, ch_result[ASFL_CH_TEMP]} :
                   hit_setup  ? {24'h000000, adc_setup_cfg} :
                   hit_thresh ? {16'h0000, current_threshold_value} :
                   hit_climit ? {16'h0000, threshold_count_limit} :
                   hit_cvalue ? {16'h0000, threshold_count_value} :
                   hit_gain   ? {24'h000000, current_gain_ctrl} :
                   hit_count  ? {16'h0000, thr_cnt} :
                                32'h00000000;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= 32'h00000000;
      else if (psel & ~penable & ~pwrite)
         prdata <= rd_mux;
   end

   ////////////////////////////////////////////////////////////////////////////
   // software registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         adc_irq_mask            <= ASFL_BYTE_RST;
         adc_mode_cfg            <= ASFL_BYTE_RST;
         adc_setup_cfg           <= ASFL_BYTE_RST;
         current_gain_ctrl       <= ASFL_BYTE_RST;
         current_threshold_value <= ASFL_WORD_RST;
         threshold_count_limit   <= ASFL_WORD_RST;
         threshold_count_value   <= ASFL_WORD_RST;
      end
      else
      begin
         if (mask_wr)   adc_irq_mask            <= pwdata[ASFL_BYTE_W-1:0];
         if (mode_wr)   adc_mode_cfg            <= pwdata[ASFL_BYTE_W-1:0];
         if (setup_wr)  adc_setup_cfg           <= pwdata[ASFL_BYTE_W-1:0];
         if (gain_wr)   current_gain_ctrl       <= pwdata[ASFL_BYTE_W-1:0];
         if (thresh_wr) current_threshold_value <= pwdata[ASFL_DATA_W-1:0];
         if (climit_wr) threshold_count_limit   <= pwdata[ASFL_DATA_W-1:0];
         if (cvalue_wr) threshold_count_value   <= pwdata[ASFL_DATA_W-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // calibration flag: a completion in the same cycle as a mode write wins
   wire logic next_cal;

   assign next_cal = cal_done ? 1'b1 :
                     mode_wr  ? 1'b0 :
                                cal_flag;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         cal_flag <= 1'b0;
      else
         cal_flag <= next_cal;
   end

   ////////////////////////////////////////////////////////////////////////////
   // comparator threshold and exceed counter
   wire logic                  cur_neg;
   wire logic [ASFL_DATA_W:0]  cur_abs;
   wire logic                  exceed;
   wire logic                  cnt_mode;
   wire logic [ASFL_CNT_W-1:0] next_cnt;
   wire logic                  next_thr;

   assign cur_neg  = ch_result[ASFL_CH_CUR][ASFL_DATA_W-1];
   assign cur_abs  = cur_neg ? (ASFL_DATA_W+1)'(17'h00000 - {1'b1, ch_result[ASFL_CH_CUR]})
                             : {1'b0, ch_result[ASFL_CH_CUR]};
   assign exceed   = ch_wr[ASFL_CH_CUR] && cur_abs > {1'b0, current_threshold_value};
   assign cnt_mode = threshold_count_limit != ASFL_WORD_RST;
   // counter saturates at all ones
   assign next_cnt = !cmp_en || climit_wr || cvalue_wr ? ASFL_WORD_RST :
                     exceed && thr_cnt != {ASFL_CNT_W{1'b1}} ? ASFL_CNT_W'(thr_cnt + 1'b1) :
                     thr_cnt;
   assign next_thr = !cmp_en                                        ? 1'b0 :
                     exceed && !cnt_mode                            ? 1'b1 :
                     exceed && next_cnt == threshold_count_value    ? 1'b1 :
                                                                      thr_flag;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         thr_cnt  <= ASFL_WORD_RST;
         thr_flag <= 1'b0;
      end
      else
      begin
         thr_cnt  <= next_cnt;
         thr_flag <= next_thr;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // gross overrange: synchronise, sample every interval, hold until cleared
   wire logic tick;
   wire logic next_govr;

   assign tick      = tick_cnt == TICK_LAST;
   assign next_govr = !ovr_en              ? 1'b0 :
                      tick && ovr_sync     ? 1'b1 :
                      gain_wr              ? 1'b0 :
                                             govr_flag;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ovr_meta  <= 1'b0;
         ovr_sync  <= 1'b0;
         tick_cnt  <= '0;
         govr_flag <= 1'b0;
      end
      else
      begin
         ovr_meta  <= gross_ovr_in;
         ovr_sync  <= ovr_meta;
         tick_cnt  <= tick ? '0 : TICK_W'(tick_cnt + 1'b1);
         govr_flag <= next_govr;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   sequence apb_setup_s;
      psel && !penable;
   endsequence

   sequence mode_write_s;
      psel && penable && pwrite && hit_mode && !cal_done;
   endsequence

   sequence status_write_s;
      psel && penable && pwrite && hit_status;
   endsequence

   status_reset_a: assert property (
      @(posedge pclk) $rose(presetn) |-> status_word == ASFL_STA_RST)
      else $error("status word not zero after reset");
   cal_set_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      cal_done |=> status_word[ASFL_STA_CAL])
      else $error("calibration done did not set status bit");
   cal_clear_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      apb_setup_s ##1 mode_write_s |=> !status_word[ASFL_STA_CAL])
      else $error("mode write did not clear calibration bit");
   reserved_zero_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      status_word[ASFL_RSV_HI:ASFL_RSV_LO] == 7'h00 && status_word[2:0] == 3'h0)
      else $error("reserved status bits not zero");
   status_ro_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      status_write_s and (!cal_done && !(|ch_valid) && !tick && !mode_wr)
      |=> $stable(cal_flag) && $stable(ch_err))
      else $error("status write changed a flag");
   thr_gate_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      !cmp_en |=> !status_word[ASFL_STA_THR])
      else $error("threshold flag set with comparator off");
   thr_set_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      exceed && cmp_en && !cnt_mode && !setup_wr |=> status_word[ASFL_STA_THR])
      else $error("threshold exceed did not set flag");
   thr_count_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      cnt_mode && $rose(thr_flag) |-> thr_cnt == threshold_count_value)
      else $error("threshold flag set before count reached");
   govr_en_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      !ovr_en |=> !govr_flag)
      else $error("overrange flag set while detection off");
   govr_tick_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      $rose(govr_flag) |-> $past(tick) && $past(ovr_sync))
      else $error("overrange flag set outside the sample interval");
   govr_sticky_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      govr_flag && ovr_en && !setup_wr && !gain_wr |=> govr_flag)
      else $error("overrange flag dropped without a clearing write");
   irq_or_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      adc_irq == |(status_word[7:0] & adc_irq_mask))
      else $error("interrupt does not match masked status bits");
endmodule
`default_nettype wire
